// ### core/acs_pkg.sv
/*
 * Shared constants and types for the calibration sequencer.
 * Assumes a 10 MHz system clock and an APB master.
 */
package acs_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam longint CLK_PERIOD_NS = 100;
  localparam longint MCLK_NOM_HZ   = 2457600;  // Nominal master
  localparam longint T_PER50_NS    = 20000000; // 50 Hz period
  localparam longint T_PER60_NS    = 16666667; // 60 Hz period
  localparam longint T_PER250_NS   = 4000000;  // 250 Hz period
  localparam longint T_PER500_NS   = 2000000;  // 500 Hz period
  localparam logic [23:0] PER50_CYC  = 24'(T_PER50_NS / CLK_PERIOD_NS);
  localparam logic [23:0] PER60_CYC  = 24'(T_PER60_NS / CLK_PERIOD_NS);
  localparam logic [23:0] PER250_CYC = 24'(T_PER250_NS / CLK_PERIOD_NS);
  localparam logic [23:0] PER500_CYC = 24'(T_PER500_NS / CLK_PERIOD_NS);
  // Pipeline delay bound, in master clock periods
  localparam longint PIPE_MAX_MCLK = 2000;
  localparam longint PIPE_MAX_NS   = PIPE_MAX_MCLK * 1000000000 / MCLK_NOM_HZ;
  localparam int     PIPE_MAX_CYC  = int'(PIPE_MAX_NS / CLK_PERIOD_NS);
  localparam int     DIV_STEPS     = 32;       // Scaling divider steps

  // ------------------------------------------------------------
  // Calibration lengths in output periods
  // ------------------------------------------------------------
  localparam logic [3:0] SELF_MODE_PER = 4'h6;
  localparam logic [3:0] SELF_RDY_PER  = 4'h9;
  localparam logic [3:0] SELF_ZS_PER   = 4'h3; // Zero-scale half
  localparam logic [3:0] SYS_MODE_PER  = 4'h3;
  localparam logic [3:0] SYS_RDY_PER   = 4'h4;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] SETUP_OFS  = 8'h00;
  localparam logic [7:0] DATA_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS   = 8'h0c;
  localparam logic [7:0] COEF_OFS   = 8'h10;
  localparam int MODE_POS = 0;  // Operating mode field [1:0]
  localparam int RATE_POS = 2;  // Filter rate select [3:2]
  localparam int BUF_POS  = 4;  // Input buffer enable
  localparam int CALD_POS = 0;  // Status: calibration done
  localparam int DNEW_POS = 1;  // Status: new data
  localparam logic [15:0] OFFS_RST = 16'h0000;
  localparam logic [15:0] SPAN_RST = 16'hffff;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_SELF   = 2'h1,
    MODE_SYS_ZS = 2'h2,
    MODE_SYS_FS = 2'h3
  } acs_mode_t;

  typedef struct packed {
    logic      buf_en;
    logic [1:0] filter_rate_select;
    acs_mode_t operating_mode_field;
  } acs_setup_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } acs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } acs_apb_rsp_t;

endpackage : acs_pkg

// ### core/acs_cal_seq.sv
/*
 * Calibration sequencer and result path of a sigma-delta converter.
 * Assumes RAW_SAMPLE_I comes from front-end logic on CLOCK_I and is
 * valid whenever an output period ends; registers sit on APB.
 */
// Overview of operation
// - Two completion signs: ready low, mode zero
// - Ready falls with fresh post-calibration result
// - Mode field clears to zero when done
// - Mode clears first, after calibration duration
// - Ready adds conversion plus bounded pipeline delay
// - Self mode: six periods, ready nine
// - Zero system mode: three periods, ready four
// - Full system mode: three periods, ready four
// - Rate field picks one of four periods
// - Setup bit selects buffered analog input
// - Read-only data register holds latest result
`timescale 1ns/1ps
module acs_cal_seq #(
  parameter logic [23:0] PER_CYC_50  = acs_pkg::PER50_CYC,
  parameter logic [23:0] PER_CYC_60  = acs_pkg::PER60_CYC,
  parameter logic [23:0] PER_CYC_250 = acs_pkg::PER250_CYC,
  parameter logic [23:0] PER_CYC_500 = acs_pkg::PER500_CYC
) (
  input  wire logic                  CLOCK_I,
  input  wire logic                  RST_N_I,
  input  wire acs_pkg::acs_apb_req_t APB_REQ_I,
  output acs_pkg::acs_apb_rsp_t      APB_RSP_O,
  input  wire logic [15:0]           RAW_SAMPLE_I,
  output logic [1:0]                 SRC_SEL_O,
  output logic                       BUF_EN_O,
  output logic                       CONVERSION_READY_LOW_O,
  output logic                       IRQ_O
);
  import acs_pkg::*;

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // The scaler must finish inside one period and the bound
  if (DIV_STEPS + 1 > PIPE_MAX_CYC) begin : g_pipe_chk
    $error("Scaling delay exceeds its bound");
  end
  if (PER_CYC_500 < 24'(DIV_STEPS + 4) || PER_CYC_250 < 24'(DIV_STEPS + 4) ||
      PER_CYC_60 < 24'(DIV_STEPS + 4) || PER_CYC_50 < 24'(DIV_STEPS + 4)) begin : g_per_chk
    $error("Output period too short for scaler");
  end

  // ------------------------------------------------------------
  // Types and declarations
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_RUN   = 4'b0001,  // Free-running conversions
    S_CAL   = 4'b0010,  // Calibration periods
    S_TAIL  = 4'b0100,  // Normal conversion after calibration
    S_SCALE = 4'b1000   // Pipeline delay: scaling divide
  } acs_state_t;

  acs_state_t  state_q, state_d;       // Sequencer state
  acs_setup_t  setup_q, setup_d;       // Setup register
  acs_mode_t   kind_q, kind_d;         // Running calibration
  logic [23:0] per_q, per_d;           // Period down-counter
  logic [3:0]  ncal_q, ncal_d;         // Periods since start
  logic [1:0]  src_q, src_d;           // Front-end source
  logic [15:0] offs_q, offs_d;         // Zero-scale coefficient
  logic [15:0] span_q, span_d;         // Full-scale span
  logic [15:0] data_q, data_d;         // Data register
  logic        rdy_low_q, rdy_low_d;   // Ready, active low
  logic [1:0]  sts_q, sts_d;           // Sticky status
  logic [1:0]  msk_q, msk_d;           // Interrupt mask
  logic [16:0] rem_q, rem_d;           // Divider remainder
  logic [31:0] num_q, num_d;           // Divider numerator/quotient
  logic [5:0]  step_q, step_d;         // Divider step count

  logic        wr_en;                  // APB write access
  logic        rd_en;                  // APB read access
  logic        tick;                   // Output period enable
  logic        cal_go;                 // Calibration start
  logic [16:0] trial;                  // Divider trial remainder
  logic [31:0] rdata;                  // Read mux

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Difference clamped at zero; sub-zero codes read as zero
  function automatic logic [15:0] sub_clamp(input logic [15:0] a,
                                            input logic [15:0] b);
    sub_clamp = (a > b) ? a - b : 16'h0000;
  endfunction : sub_clamp

  // Output period in cycles for a rate code
  function automatic logic [23:0] rate_cyc(input logic [1:0] sel);
    unique case (sel)
      2'h0:    rate_cyc = PER_CYC_50;
      2'h1:    rate_cyc = PER_CYC_60;
      2'h2:    rate_cyc = PER_CYC_250;
      default: rate_cyc = PER_CYC_500;
    endcase
  endfunction : rate_cyc

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  // Zero wait states: every access completes in its first cycle
  assign wr_en = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite;
  assign rd_en = APB_REQ_I.psel & APB_REQ_I.penable & ~APB_REQ_I.pwrite;

  // Read mux and error flag for unmapped addresses
  always_comb begin
    rdata = 32'h0000_0000;
    APB_RSP_O.pslverr = 1'b0;
    unique case (APB_REQ_I.paddr)
      SETUP_OFS:  rdata = {27'h0, setup_q};
      DATA_OFS:   rdata = {16'h0, data_q};
      STATUS_OFS: rdata = {30'h0, sts_q};
      MASK_OFS:   rdata = {30'h0, msk_q};
      COEF_OFS:   rdata = {span_q, offs_q};
      default:    APB_RSP_O.pslverr = APB_REQ_I.psel & APB_REQ_I.penable;
    endcase
    APB_RSP_O.prdata = rdata;
    APB_RSP_O.pready = 1'b1;
  end

  // A mode write starts calibration unless one is already running
  assign cal_go = wr_en && (APB_REQ_I.paddr == SETUP_OFS) &&
                  (APB_REQ_I.pwdata[MODE_POS +: 2] != 2'h0) && (state_q != S_CAL);

  // Period divider: one-cycle tick per output period
  assign tick = (per_q == 24'h0);

  // Shifted partial remainder for one restoring-divide step
  assign trial = {rem_q[15:0], num_q[31]};

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    setup_d   = setup_q;
    kind_d    = kind_q;
    per_d     = tick ? rate_cyc(setup_q.filter_rate_select) - 24'h1 : per_q - 24'h1;
    ncal_d    = ncal_q;
    src_d     = src_q;
    offs_d    = offs_q;
    span_d    = span_q;
    data_d    = data_q;
    rdy_low_d = rdy_low_q;
    sts_d     = sts_q;
    msk_d     = msk_q;
    rem_d     = rem_q;
    num_d     = num_q;
    step_d    = step_q;

    // Register writes; mode is frozen while calibrating
    if (wr_en) begin
      unique case (APB_REQ_I.paddr)
        SETUP_OFS: begin
          setup_d.buf_en = APB_REQ_I.pwdata[BUF_POS];
          setup_d.filter_rate_select = APB_REQ_I.pwdata[RATE_POS +: 2];
          if (cal_go) begin
            setup_d.operating_mode_field = acs_mode_t'(APB_REQ_I.pwdata[MODE_POS +: 2]);
          end
        end
        STATUS_OFS: sts_d = sts_q & ~APB_REQ_I.pwdata[1:0];
        MASK_OFS:   msk_d = APB_REQ_I.pwdata[1:0];
        default: ;  // Data and coefficients are read-only
      endcase
    end

    // Reading the data register retires the ready indication
    if (rd_en && (APB_REQ_I.paddr == DATA_OFS)) begin
      rdy_low_d = 1'b1;
    end

    unique case (state_q)
      // Normal conversions: hand each sample to the scaler
      S_RUN: begin
        if (tick) begin
          state_d = S_SCALE;
        end
      end
      // Count calibration periods and capture coefficients
      S_CAL: begin
        if (tick) begin
          ncal_d = ncal_q + 4'h1;
          if (kind_q == MODE_SELF) begin
            if (ncal_d == SELF_ZS_PER) begin
              offs_d = RAW_SAMPLE_I;
              src_d  = 2'h2;          // Internal full-scale next
            end
            if (ncal_d == SELF_MODE_PER) begin
              span_d = sub_clamp(RAW_SAMPLE_I, offs_q);
            end
          end else if (ncal_d == SYS_MODE_PER) begin
            if (kind_q == MODE_SYS_ZS) begin
              offs_d = RAW_SAMPLE_I;
            end else begin
              span_d = sub_clamp(RAW_SAMPLE_I, offs_q);
            end
          end
          // Mode clears after the calibration's own periods
          if (ncal_d == ((kind_q == MODE_SELF) ? SELF_MODE_PER : SYS_MODE_PER)) begin
            setup_d.operating_mode_field = MODE_NORMAL;
            sts_d[CALD_POS] = 1'b1;
            src_d   = 2'h0;
            state_d = S_TAIL;
          end
        end
      end
      // Normal conversions before the first result: one period for system modes, three for self
      S_TAIL: begin
        if (tick) begin
          ncal_d = ncal_q + 4'h1;
          if (ncal_d == ((kind_q == MODE_SELF) ? SELF_RDY_PER : SYS_RDY_PER)) begin
            state_d = S_SCALE;
          end
        end
      end
      // Scaling divide; its length is the pipeline delay
      S_SCALE: begin
        if (step_q == 6'(DIV_STEPS)) begin
          data_d    = (num_q[31:16] != 16'h0) ? 16'hffff : num_q[15:0];
          rdy_low_d = 1'b0;
          sts_d[DNEW_POS] = 1'b1;
          state_d   = S_RUN;
        end else begin
          step_d = step_q + 6'h1;
          if (trial >= {1'b0, span_q}) begin
            rem_d = trial - {1'b0, span_q};
            num_d = {num_q[30:0], 1'b1};
          end else begin
            rem_d = trial;
            num_d = {num_q[30:0], 1'b0};
          end
        end
      end
      default: state_d = S_RUN;
    endcase

    // Load the scaler with the offset-corrected sample
    if ((state_d == S_SCALE) && (state_q != S_SCALE)) begin
      num_d  = {sub_clamp(RAW_SAMPLE_I, offs_q), 16'h0000};
      rem_d  = 17'h0;
      step_d = 6'h0;
    end

    // Calibration start restarts the period and raises ready high
    if (cal_go) begin
      kind_d    = acs_mode_t'(APB_REQ_I.pwdata[MODE_POS +: 2]);
      state_d   = S_CAL;
      ncal_d    = 4'h0;
      per_d     = rate_cyc(APB_REQ_I.pwdata[RATE_POS +: 2]) - 24'h1;
      src_d     = (APB_REQ_I.pwdata[MODE_POS +: 2] == 2'h1) ? 2'h1 : 2'h0;
      rdy_low_d = 1'b1;
    end

    // Hardware set wins over a same-cycle clear
    if ((state_q == S_CAL) && (state_d == S_TAIL)) begin
      sts_d[CALD_POS] = 1'b1;
    end
    if ((state_q == S_SCALE) && (state_d == S_RUN)) begin
      sts_d[DNEW_POS] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q   <= S_RUN;
      setup_q   <= '0;
      kind_q    <= MODE_NORMAL;
      per_q     <= PER_CYC_50 - 24'h1;
      ncal_q    <= 4'h0;
      src_q     <= 2'h0;
      offs_q    <= OFFS_RST;
      span_q    <= SPAN_RST;
      data_q    <= 16'h0000;
      rdy_low_q <= 1'b1;
      sts_q     <= 2'h0;
      msk_q     <= 2'h0;
      rem_q     <= 17'h0;
      num_q     <= 32'h0;
      step_q    <= 6'h0;
    end else begin
      state_q   <= state_d;
      setup_q   <= setup_d;
      kind_q    <= kind_d;
      per_q     <= per_d;
      ncal_q    <= ncal_d;
      src_q     <= src_d;
      offs_q    <= offs_d;
      span_q    <= span_d;
      data_q    <= data_d;
      rdy_low_q <= rdy_low_d;
      sts_q     <= sts_d;
      msk_q     <= msk_d;
      rem_q     <= rem_d;
      num_q     <= num_d;
      step_q    <= step_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign SRC_SEL_O              = src_q;
  assign BUF_EN_O               = setup_q.buf_en;
  assign CONVERSION_READY_LOW_O = rdy_low_q;
  // Level interrupt while any unmasked status bit is set
  assign IRQ_O                  = |(sts_q & msk_q);

endmodule : acs_cal_seq

// ### dv/acs_cal_seq_asserts.sv
/* Checker for the calibration sequencer ports.
   Assumes one calibration at a time and no mode write while one runs. */
`timescale 1ns/1ps
module acs_cal_seq_chk
  import acs_pkg::*;
#(
  parameter logic [23:0] PER_CYC_50  = 24'h64,
  parameter logic [23:0] PER_CYC_60  = 24'h5a,
  parameter logic [23:0] PER_CYC_250 = 24'h3c,
  parameter logic [23:0] PER_CYC_500 = 24'h32
) (
  input wire logic                  CLOCK_I,
  input wire logic                  RST_N_I,
  input wire acs_pkg::acs_apb_req_t APB_REQ_I,
  input wire acs_pkg::acs_apb_rsp_t APB_RSP_O,
  input wire logic [1:0]            SRC_SEL_O,
  input wire logic                  BUF_EN_O,
  input wire logic                  CONVERSION_READY_LOW_O,
  input wire logic                  IRQ_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  // ----------------------------------------------------------
  // Helper: cycles since the accepted calibration command
  // ----------------------------------------------------------
  wire logic acc = APB_REQ_I.psel && APB_REQ_I.penable;
  wire logic rd = acc && !APB_REQ_I.pwrite;
  wire logic set_wr = acc && APB_REQ_I.pwrite && APB_REQ_I.paddr == SETUP_OFS;
  logic        armed_q, armed_d;  // Calibration in flight
  logic [15:0] cnt_q, cnt_d;      // Cycles since command
  logic [15:0] p_q, p_d;          // Period of the chosen rate
  logic [1:0]  md_q, md_d;        // Mode that was started
  logic [23:0] per;
  wire logic slf = md_q == 2'h1;
  wire logic [15:0] np = p_q * (slf ? 16'h6 : 16'h3);
  wire logic [15:0] nr = p_q * (slf ? 16'h9 : 16'h4) + 16'h21;
  // Next state; saturating counter not needed, runs are short
  always_comb begin
    case (APB_REQ_I.pwdata[3:2])
      2'h0: per = PER_CYC_50;
      2'h1: per = PER_CYC_60;
      2'h2: per = PER_CYC_250;
      default: per = PER_CYC_500;
    endcase
    armed_d = armed_q;
    cnt_d = cnt_q + 16'h1;
    p_d = p_q;
    md_d = md_q;
    if (set_wr && !armed_q && APB_REQ_I.pwdata[1:0] != 2'h0) begin
      armed_d = 1'b1;
      cnt_d = 16'h0;
      p_d = per[15:0];
      md_d = APB_REQ_I.pwdata[1:0];
    end else if (armed_q && cnt_q > 16'h1 && !CONVERSION_READY_LOW_O) begin
      armed_d = 1'b0;
    end
  end
  // Register stage
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      armed_q <= 1'b0;
      cnt_q <= 16'h0;
      p_q <= 16'h0;
      md_q <= 2'h0;
    end else begin
      armed_q <= armed_d;
      cnt_q <= cnt_d;
      p_q <= p_d;
      md_q <= md_d;
    end
  end
  sequence s_cal_cmd;
    set_wr && APB_REQ_I.pwdata[1:0] != 2'h0;
  endsequence
  sequence s_rdy_up;
    ##[1:2] CONVERSION_READY_LOW_O;
  endsequence
  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  a_ready_rises_cal: assert property (s_cal_cmd |-> s_rdy_up)
    else $error("ready not raised by calibration command");
  a_ready_held_high: assert property (armed_q && cnt_q >= 16'h1 && cnt_q < nr
    |-> CONVERSION_READY_LOW_O)
    else $error("ready fell before calibration and conversion");
  a_ready_fall_time: assert property ($fell(CONVERSION_READY_LOW_O) && armed_q
    |-> cnt_q == nr)
    else $error("ready fell at wrong cycle");
  a_mode_read_back: assert property (rd && APB_REQ_I.paddr == SETUP_OFS && armed_q
    |-> APB_RSP_O.prdata[1:0] == (cnt_q >= np ? 2'h0 : md_q))
    else $error("mode field cleared at wrong cycle");
  a_src_self_only: assert property (SRC_SEL_O != 2'h0 |-> armed_q && slf)
    else $error("internal source outside self calibration");
  a_buf_follows_bit: assert property (set_wr
    |=> BUF_EN_O == $past(APB_REQ_I.pwdata[BUF_POS]))
    else $error("buffer enable not following setup");
  a_data_upper_zero: assert property (rd && APB_REQ_I.paddr == DATA_OFS
    |-> APB_RSP_O.prdata[31:16] == 16'h0)
    else $error("data word wider than sixteen bits");
  a_pready_always_on: assert property (acc |-> APB_RSP_O.pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (acc && APB_REQ_I.paddr > COEF_OFS
    |-> APB_RSP_O.pslverr && APB_RSP_O.prdata == 32'h0)
    else $error("unmapped access not refused");
  a_irq_mask_zero: assert property (rd && APB_REQ_I.paddr == MASK_OFS
    && APB_RSP_O.prdata[1:0] == 2'h0 |-> !IRQ_O)
    else $error("interrupt with all masked");
endmodule : acs_cal_seq_chk

bind acs_cal_seq acs_cal_seq_chk #(
  .PER_CYC_50(PER_CYC_50), .PER_CYC_60(PER_CYC_60),
  .PER_CYC_250(PER_CYC_250), .PER_CYC_500(PER_CYC_500)
) i_chk (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .APB_REQ_I(APB_REQ_I),
  .APB_RSP_O(APB_RSP_O), .SRC_SEL_O(SRC_SEL_O), .BUF_EN_O(BUF_EN_O),
  .CONVERSION_READY_LOW_O(CONVERSION_READY_LOW_O), .IRQ_O(IRQ_O));

// ### dv/acs_front_model.sv
/* Front-end model: raw code chosen by the source select.
   Assumes the bench drives the analog code on the sequencer clock. */
`timescale 1ns/1ps
module acs_front_model #(
  parameter logic [15:0] ZS_LEVEL = 16'h0123, // Internal zero code
  parameter logic [15:0] FS_LEVEL = 16'hf00d  // Internal full code
) (
  input  wire logic [1:0]  src_sel_i,
  input  wire logic [15:0] analog_i,
  output logic [15:0]      raw_o
);
  // Unused code 3 reads inverted input, so a stray select shows
  always_comb begin
    case (src_sel_i)
      2'h0: raw_o = analog_i;
      2'h1: raw_o = ZS_LEVEL;
      2'h2: raw_o = FS_LEVEL;
      default: raw_o = ~analog_i;
    endcase
  end
endmodule : acs_front_model

// ### dv/tb_top.sv
/* Self-checking bench: three calibration kinds over APB.
   Assumes shortened periods and a zero-wait APB slave. */
`timescale 1ns/1ps
module tb_top;
  import acs_pkg::*;
  localparam logic [15:0] ZSL = 16'h0123;
  localparam logic [15:0] FSL = 16'hf00d;
  logic         clk;
  logic         rst_n;
  acs_apb_req_t req;
  acs_apb_rsp_t rsp;
  logic [15:0]  raw, analog, lfsr, off_m, span_m;
  logic [1:0]   src;
  logic         buf_en, rdy_n, irq, rerr;
  logic [31:0]  rdat;
  int           n_fail = 0;
  int           samples_checked = 0;
  acs_cal_seq #(.PER_CYC_50(24'h64), .PER_CYC_60(24'h5a), .PER_CYC_250(24'h3c),
    .PER_CYC_500(24'h32)) i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .APB_REQ_I(req),
    .APB_RSP_O(rsp), .RAW_SAMPLE_I(raw), .SRC_SEL_O(src), .BUF_EN_O(buf_en),
    .CONVERSION_READY_LOW_O(rdy_n), .IRQ_O(irq));
  acs_front_model #(.ZS_LEVEL(ZSL), .FS_LEVEL(FSL)) i_front (.src_sel_i(src),
    .analog_i(analog), .raw_o(raw));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  // Expected scaled result, clamped both ends
  function automatic logic [15:0] scale(logic [15:0] r, logic [15:0] o, logic [15:0] s);
    logic [32:0] q;
    q = (r > o) ? {1'b0, r - o, 16'h0} : 33'h0;
    if (s == 16'h0) return 16'hffff;
    q = q / s;
    return (q > 33'hffff) ? 16'hffff : q[15:0];
  endfunction : scale
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer; request held until pready sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  // Start one calibration, wait both completion signs, check results
  task automatic cal(input logic [1:0] md);
    logic [15:0] a, b;
    logic        bf;
    logic [1:0]  rt;
    int          i;
    a = (md == 2'h2) ? (rnd() & 16'h0fff) : (rnd() | 16'h8000);
    bf = rnd() > 16'h8000;
    // Rate code kept at two bits so the buffer bit lands in place
    rt = 2'(rnd());
    analog <= a;
    apb(1'b1, MASK_OFS, {31'h0, md != 2'h3});
    apb(1'b1, SETUP_OFS, {27'h0, bf, rt, md});
    repeat (2) @(posedge clk);
    chk("buf_en", bf, buf_en);
    chk("ready_high", 1'b1, rdy_n);
    i = 0;
    do begin
      apb(1'b0, SETUP_OFS, 32'h0);
      i++;
    end while (rdat[1:0] !== 2'h0 && i < 400);
    chk("mode_clear", 2'h0, rdat[1:0]);
    chk("ready_after_mode", 1'b1, rdy_n);
    b = rnd();
    analog <= b;
    if (md == 2'h2) off_m = a;
    if (md == 2'h3) span_m = a - off_m;
    if (md == 2'h1) {off_m, span_m} = {ZSL, FSL - ZSL};
    for (i = 0; i < 2000 && rdy_n !== 1'b0; i++) @(posedge clk);
    chk("ready_low", 1'b0, rdy_n);
    apb(1'b0, DATA_OFS, 32'h0);
    chk("data", {16'h0, scale(b, off_m, span_m)}, rdat);
    apb(1'b0, COEF_OFS, 32'h0);
    chk("coef", {span_m, off_m}, rdat);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("status", 32'h3, rdat);
    chk("irq", md != 2'h3, irq);
    apb(1'b1, STATUS_OFS, 32'h1);
    @(posedge clk);
    chk("irq_clear", 1'b0, irq);
  endtask : cal
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // Watchdog: three runs need under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    results();
  end
  // Main sequence
  initial begin
    rst_n = 1'b0;
    req = '0;
    analog = 16'h0;
    lfsr = 16'h523b;
    off_m = 16'h0;
    span_m = 16'hffff;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, SETUP_OFS, 32'h0);
    chk("setup_rst", 32'h0, rdat);
    apb(1'b0, COEF_OFS, 32'h0);
    chk("coef_rst", 32'hffff0000, rdat);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", 1'b1, rerr);
    cal(2'h2);
    cal(2'h3);
    cal(2'h1);
    results();
  end
endmodule : tb_top
